/* logic/nvsp_consts.vh */
// constants for the nonvolatile sram host controller
`ifndef NVSP_CONSTS_VH
`define NVSP_CONSTS_VH
`define NVSP_AW 13
`define NVSP_DW 8
`define NVSP_SEQ0 13'h0000
`define NVSP_SEQ1 13'h1555
`define NVSP_SEQ2 13'h0aaa
`define NVSP_SEQ3 13'h1fff
`define NVSP_SEQ4 13'h10f0
`define NVSP_SEQ_STORE 13'h0f0f
`define NVSP_SEQ_RECALL 13'h0f0e
`define NVSP_CLK_MHZ 125
`define NVSP_STORE_MS 10
`define NVSP_POWERUP_RECALL_US 550
`define NVSP_RECALL_US 20
`define NVSP_STORE_CYC (`NVSP_STORE_MS * 1000 * `NVSP_CLK_MHZ)
`define NVSP_POWERUP_CYC (`NVSP_POWERUP_RECALL_US * `NVSP_CLK_MHZ)
`define NVSP_RECALL_CYC (`NVSP_RECALL_US * `NVSP_CLK_MHZ)
`define NVSP_PHASE_NS 40
`define NVSP_PHASE_CYC ((`NVSP_PHASE_NS + 7) / 8)
`define NVSP_OP_READ 2'h0
`define NVSP_OP_WRITE 2'h1
`define NVSP_OP_STORE 2'h2
`define NVSP_OP_RECALL 2'h3
`endif

/* logic/nvsp_host.v */
// host controller driving a nonvolatile sram over its async pins
// Function
// (RQ1) write strobe high in reads, low in writes
// (RQ2) device tristates if write precedes select
// (RQ3) address changes only with select high
// (RQ4) store after six-read sequence ending 0f0f
// (RQ5) recall after six-read sequence ending 0f0e
// (RQ6) trigger addresses issued strictly in order
// (RQ7) write strobe high through all trigger reads
// (RQ8) sixth trigger read returns no data
// (RQ9) store finishes within 10 ms
// (RQ10) power-up recall finishes within 550 us
// (RQ11) no other access inserted in sequence
// (RQ12) device ignores pins during store
// (RQ13) each trigger read framed by select pulse
// (RQ14) write when select and strobe low
// (RQ15) detector restarts on mismatch or 0000
`include "nvsp_consts.vh"
module nvsp_host #(
  parameter STORE_CYC = `NVSP_STORE_CYC,
  parameter POWERUP_CYC = `NVSP_POWERUP_CYC,
  parameter RECALL_CYC = `NVSP_RECALL_CYC
) (
  clk,
  rst_b,
  req_valid,
  req_ready,
  req_op,
  req_addr,
  req_wdata,
  rsp_valid,
  rsp_rdata,
  busy,
  mem_ce_b,
  mem_we_b,
  mem_oe_b,
  address_lines,
  data_lines_o,
  data_lines_oe,
  data_lines_i
);
  input wire clk;
  input wire rst_b;
  input wire req_valid;
  output wire req_ready;
  input wire [1:0] req_op;
  input wire [12:0] req_addr;
  input wire [7:0] req_wdata;
  output reg rsp_valid;
  output reg [7:0] rsp_rdata;
  output wire busy;
  output reg mem_ce_b;
  output reg mem_we_b;
  output reg mem_oe_b;
  output reg [12:0] address_lines;
  output reg [7:0] data_lines_o;
  output reg data_lines_oe;
  input wire [7:0] data_lines_i;

  localparam S_PWRUP = 3'h0;
  localparam S_IDLE = 3'h1;
  localparam S_SETUP = 3'h2;
  localparam S_ACT = 3'h3;
  localparam S_HOLD = 3'h4;
  localparam S_NVWAIT = 3'h5;
  localparam integer PHASE_INT = `NVSP_PHASE_CYC;
  localparam [23:0] PHASE_CYC = PHASE_INT[23:0];

  reg [2:0] state_r;
  reg [1:0] op_r;
  reg [2:0] step_r;
  reg [7:0] din_s1_r;
  reg [7:0] din_s2_r;
  reg load;
  reg [23:0] load_val;
  wire t_done;

  function [12:0] seq_addr;
    input [2:0] step;
    input [1:0] op;
    begin
      case (step)
        3'h0: seq_addr = `NVSP_SEQ0;
        3'h1: seq_addr = `NVSP_SEQ1;
        3'h2: seq_addr = `NVSP_SEQ2;
        3'h3: seq_addr = `NVSP_SEQ3;
        3'h4: seq_addr = `NVSP_SEQ4;
        default: seq_addr = (op == `NVSP_OP_STORE) ? `NVSP_SEQ_STORE : `NVSP_SEQ_RECALL;
      endcase
    end
  endfunction

  nvsp_wait u_wait (
    .clk(clk),
    .rst_b(rst_b),
    .load(load),
    .count(load_val),
    .done(t_done)
  );

  // one request at a time keeps the trigger reads uninterrupted
  assign req_ready = (state_r == S_IDLE); // [RQ11]
  assign busy = (state_r != S_IDLE);

  // data pins come from outside the clock domain
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      din_s1_r <= 8'h00;
      din_s2_r <= 8'h00;
    end else begin
      din_s1_r <= data_lines_i;
      din_s2_r <= din_s1_r;
    end
  end

  always @* begin
    load = 1'b0;
    load_val = PHASE_CYC;
    case (state_r)
      // device is still restoring after power-up, so hold requests off
      S_PWRUP: begin
        load = (step_r == 3'h0);
        load_val = POWERUP_CYC[23:0]; // [RQ10]
      end
      S_IDLE: load = req_valid;
      S_SETUP: load = t_done;
      S_ACT: load = t_done;
      S_HOLD: begin
        if (t_done && step_r == 3'h5) begin
          load = 1'b1;
          // store and recall have their own worst-case waits
          load_val = (op_r == `NVSP_OP_STORE) ? STORE_CYC[23:0] : RECALL_CYC[23:0]; // [RQ9]
        end else if (t_done && op_r[1]) begin
          load = 1'b1;
        end
      end
      default: load = 1'b0;
    endcase
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= S_PWRUP;
      op_r <= `NVSP_OP_READ;
      step_r <= 3'h0;
      rsp_valid <= 1'b0;
      rsp_rdata <= 8'h00;
      mem_ce_b <= 1'b1;
      mem_we_b <= 1'b1;
      mem_oe_b <= 1'b1;
      address_lines <= 13'h0000;
      data_lines_o <= 8'h00;
      data_lines_oe <= 1'b0;
    end else begin
      rsp_valid <= 1'b0;
      case (state_r)
        S_PWRUP: begin
          // counter is zero after reset, so reload once then wait it out
          if (step_r == 3'h0) begin
            step_r <= 3'h1;
          end else if (t_done) begin
            step_r <= 3'h0;
            state_r <= S_IDLE; // [RQ10]
          end
        end
        S_IDLE: begin
          if (req_valid) begin
            op_r <= req_op;
            step_r <= 3'h0;
            // address set while select is high
            address_lines <= req_op[1] ? `NVSP_SEQ0 : req_addr; // [RQ3]
            data_lines_o <= req_wdata;
            state_r <= S_SETUP;
          end
        end
        S_SETUP: begin
          if (t_done) begin
            mem_ce_b <= 1'b0; // [RQ13]
            if (op_r == `NVSP_OP_WRITE) begin
              mem_we_b <= 1'b0; // [RQ1] [RQ14]
              data_lines_oe <= 1'b1;
            end else begin
              mem_we_b <= 1'b1; // [RQ1] [RQ7]
              // sixth trigger read gets no data, so keep output enable off
              mem_oe_b <= (op_r[1] && step_r == 3'h5) ? 1'b1 : 1'b0; // [RQ8]
            end
            state_r <= S_ACT;
          end
        end
        S_ACT: begin
          if (t_done) begin
            mem_ce_b <= 1'b1;
            mem_we_b <= 1'b1;
            mem_oe_b <= 1'b1;
            if (op_r == `NVSP_OP_READ) begin
              rsp_rdata <= din_s2_r;
            end
            state_r <= S_HOLD;
          end
        end
        S_HOLD: begin
          if (t_done) begin
            data_lines_oe <= 1'b0;
            if (op_r[1] && step_r != 3'h5) begin
              step_r <= step_r + 3'h1;
              address_lines <= seq_addr(step_r + 3'h1, op_r); // [RQ4] [RQ5] [RQ6] [RQ3]
              state_r <= S_SETUP;
            end else if (op_r[1]) begin
              // pins stay idle while the device is busy
              state_r <= S_NVWAIT; // [RQ12]
            end else begin
              rsp_valid <= 1'b1;
              state_r <= S_IDLE;
            end
          end
        end
        S_NVWAIT: begin
          if (t_done) begin
            step_r <= 3'h0;
            rsp_valid <= 1'b1;
            state_r <= S_IDLE;
          end
        end
        default: state_r <= S_IDLE;
      endcase
    end
  end
endmodule

/* logic/nvsp_wait.v */
// down counter that times pin phases and nonvolatile waits
`include "nvsp_consts.vh"
module nvsp_wait (
  clk,
  rst_b,
  load,
  count,
  done
);
  input wire clk;
  input wire rst_b;
  input wire load;
  input wire [23:0] count;
  output wire done;
  reg [23:0] cnt_r;
  assign done = (cnt_r == 24'h000000);
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r <= 24'h000000;
    end else if (load) begin
      cnt_r <= count;
    end else if (cnt_r != 24'h000000) begin
      cnt_r <= cnt_r - 24'h000001;
    end
  end
endmodule

/* tb/nvsp_assertions.sv */
// pin-level assertions for the host controller
module nvsp_assertions (
  input logic clk,
  input logic rst_b,
  input logic req_valid,
  input logic req_ready,
  input logic [1:0] req_op,
  input logic mem_ce_b,
  input logic mem_we_b,
  input logic mem_oe_b,
  input logic [12:0] address_lines
);
  timeunit 1ns;
  timeprecision 1ps;
  logic seq_on;
  // remembers whether the request in flight is a trigger sequence
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      seq_on <= 1'b0;
    end else if (req_valid && req_ready) begin
      seq_on <= req_op[1];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  seq_we_all_a: assert property (seq_on |-> mem_we_b)
    else $error("strobe low inside trigger sequence");
  last_read_off_a: assert property (seq_on && !mem_ce_b && address_lines[12:1] == 12'h787 |-> mem_oe_b)
    else $error("output enable low on final trigger read");
  rd_we_high_a: assert property (!mem_oe_b |-> mem_we_b)
    else $error("strobe low during read");
  wr_oe_high_a: assert property (!mem_we_b |-> mem_oe_b)
    else $error("output enable low during write");
  addr_hold_a: assert property (!mem_ce_b && !mem_we_b |=> mem_ce_b || mem_we_b || $stable(address_lines))
    else $error("address moved in write");
  ce_pulse_a: assert property ($fell(mem_ce_b) |-> ##[1:12] mem_ce_b)
    else $error("select not pulsed");
  seq_start_a: assert property (req_valid && req_ready && req_op[1] |-> ##[1:12] !mem_ce_b && address_lines == 13'h0000)
    else $error("sequence not started at zero");
  seq_we_a: assert property (req_valid && req_ready && req_op[1] |=> mem_we_b [*8])
    else $error("strobe low in sequence");
endmodule

bind nvsp_host nvsp_assertions nvsp_assertions_i (.clk, .rst_b, .req_valid, .req_ready, .req_op,
  .mem_ce_b, .mem_we_b, .mem_oe_b, .address_lines);

/* tb/nvsp_dev_model.sv */
// behavioural model of the nonvolatile sram device
module nvsp_dev_model #(
  parameter int ST_NS = 300,
  parameter int RC_NS = 100,
  parameter int PU_NS = 300
) (
  input logic ce_b,
  input logic we_b,
  input logic oe_b,
  input logic [12:0] a,
  input logic [7:0] d,
  output logic [7:0] q,
  output logic q_en
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [8192];
  logic [7:0] nv [8192];
  logic [12:0] sq [5] = '{13'h0000, 13'h1555, 13'h0aaa, 13'h1fff, 13'h10f0};
  int stp = 0;
  bit busy = 1;
  initial q = 8'h00;
  initial #(PU_NS) busy = 0;
  // a strobe already low keeps lines off; busy covers the sixth read
  assign q_en = !busy && !ce_b && !oe_b && we_b;
  // released lines flip so a stale byte never passes for data
  always @(q_en, a) q = q_en ? mem[a] : ~q;
  always @(ce_b, we_b, a, d) if (!busy && !ce_b && !we_b) begin
    mem[a] = d;
    stp = 0;
  end
  always @(negedge ce_b) if (!busy && we_b) begin
    if (stp == 5 && a[12:1] == 12'h787) begin
      busy = 1;
      if (a[0]) nv = mem;
      else mem = nv;
      #(a[0] ? ST_NS : RC_NS);
      busy = 0;
      stp = 0;
    end else stp = (stp < 5 && a == sq[stp]) ? stp + 1 : int'(a == 13'h0000);
  end
endmodule

/* tb/tb_nvsp_host.sv */
// testbench for the nonvolatile sram host controller
module tb_nvsp_host;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst_b = 0, req_valid = 0;
  logic [1:0] req_op = 0;
  logic [12:0] req_addr = 0, ad;
  logic [7:0] req_wdata = 0, rd1, wd;
  logic [8:0] exp_q [$];
  logic [8:0] e;
  logic [31:0] x = 32'h02fc41be;
  int n_errors = 0, compares = 0, cyc = 0;
  wire req_ready, rsp_valid, busy, mem_ce_b, mem_we_b, mem_oe_b, data_lines_oe, q_en;
  wire [7:0] rsp_rdata, data_lines_o, q;
  wire [12:0] address_lines;
  wire [7:0] dbus = data_lines_oe ? data_lines_o : q;
  nvsp_host #(.STORE_CYC(50), .POWERUP_CYC(50), .RECALL_CYC(50)) nvsp_host_i (.clk, .rst_b,
    .req_valid, .req_ready, .req_op, .req_addr, .req_wdata, .rsp_valid, .rsp_rdata, .busy,
    .mem_ce_b, .mem_we_b, .mem_oe_b, .address_lines, .data_lines_o, .data_lines_oe,
    .data_lines_i(dbus));
  nvsp_dev_model nvsp_dev_model_i (.ce_b(mem_ce_b), .we_b(mem_we_b), .oe_b(mem_oe_b),
    .a(address_lines), .d(dbus), .q, .q_en);
  initial forever #4 clk = ~clk;
  function logic [31:0] rnd();
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  task report_and_stop;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task chk(input logic [7:0] got, input logic [7:0] ex);
    compares++;
    if (got !== ex) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, ex);
    end
  endtask
  task op(input logic [1:0] o, input logic [12:0] a, input logic [7:0] w, input logic [8:0] ex);
    @(negedge clk);
    while (req_ready !== 1'b1) @(negedge clk);
    req_valid = 1;
    req_op = o;
    req_addr = a;
    req_wdata = w;
    exp_q.push_back(ex);
    @(negedge clk);
    req_valid = 0;
    chk({7'h00, busy}, 8'h01);
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      report_and_stop;
    end
  end
  always @(negedge clk) if (rsp_valid === 1'b1) begin
    e = exp_q.pop_front();
    if (e[8] === 1'b1) chk(rsp_rdata, e[7:0]);
  end
  initial begin
    repeat (20) @(negedge clk);
    rst_b = 1;
    repeat (40) @(negedge clk);
    chk({7'h00, req_ready}, 8'h00);
    for (int i = 0; i < 4; i++) begin
      ad = 13'(rnd());
      wd = 8'(rnd());
      op(2'h1, ad, wd, 9'h000);
      op(2'h0, ad, 8'h00, {1'b1, wd});
    end
    rd1 = 8'(rnd());
    op(2'h1, 13'h0123, rd1, 9'h000);
    op(2'h2, 13'h0000, 8'h00, 9'h000);
    op(2'h1, 13'h0123, ~rd1, 9'h000);
    op(2'h0, 13'h0123, 8'h00, {1'b1, ~rd1});
    op(2'h3, 13'h0000, 8'h00, 9'h000);
    op(2'h0, 13'h0123, 8'h00, {1'b1, rd1});
    repeat (40) @(negedge clk);
    chk(8'(exp_q.size()), 8'h00);
    report_and_stop;
  end
endmodule
